/* File: design/fls_defines.vh */
// constants for the flash lock security checker
`ifndef FLS_DEFINES_VH
`define FLS_DEFINES_VH
// operation codes on the request port
`define FLS_OP_READ      2'h0
`define FLS_OP_WRITE     2'h1
`define FLS_OP_ERASE     2'h2
`define FLS_OP_DEV_ERASE 2'h3
// verdict codes
`define FLS_V_ALLOW      2'h0
`define FLS_V_REFUSE     2'h1
`define FLS_V_FAULT      2'h2
// erased value of the lock byte (erased flash, nothing locked)
`define FLS_LOCK_ERASED  8'hFF
// default geometry
`define FLS_PAGE_W       6
`define FLS_LOCK_PAGE    6'h3F
`define FLS_RSV_FIRST    6'h3F
`endif

/* File: design/fls_page_lock.v */
// page lock state decode from the effective lock byte
`timescale 1ns/1ps
module fls_page_lock #(
   parameter PAGE_W = 6
) (
   // lock state
   input  wire [7:0]        lock_val,
   // page under test
   input  wire [PAGE_W-1:0] page,
   input  wire              is_lock_page,
   // result
   output wire              any_locked,
   output wire              page_locked
);
   // pages below 255-lock_val counted as locked; 0xFF locks none
   wire [8:0] nlock;
   assign nlock = {1'b0, ~lock_val};
   assign any_locked = (lock_val != 8'hFF);
   // lock page locked whenever any page is locked
   assign page_locked = (is_lock_page & any_locked)
                      | ({{(9-PAGE_W){1'b0}}, page} < nlock);
endmodule

/* File: design/fls_checker.v */
// flash lock security checker top
//
// Overview of operation
// - unlocked pages open to every requester
// - locked page: debug refused, unlocked firmware faults
// - lock page access follows locked policy
// - reading lock byte follows same policy
// - lock page erase: debug only, firmware faults
// - when locked, only device erase clears
// - locking more pages is forbidden
// - unlocking single pages is forbidden
// - reserved area: debug refused, firmware faults
// - firmware fault resets, sets fault flag
// - refused debug requests change nothing
// - any lock also locks the lock page
// - written lock byte frozen until device erase or allowed lock page erase
// - firmware lock write applies after reset
`timescale 1ns/1ps
`include "fls_defines.vh"
module fls_checker #(
   parameter PAGE_W    = `FLS_PAGE_W,
   parameter LOCK_PAGE = `FLS_LOCK_PAGE,
   parameter RSV_FIRST = `FLS_RSV_FIRST
) (
   // clock and reset
   input  wire              ref_clk,
   input  wire              rstn,
   input  wire              clk_en,
   // request
   input  wire              req_valid,
   input  wire              req_from_debug,
   input  wire [1:0]        req_op,
   input  wire [PAGE_W-1:0] req_page,
   input  wire              req_lock_byte,
   input  wire              req_rsv,
   input  wire [7:0]        req_wdata,
   input  wire [PAGE_W-1:0] exec_page,
   // verdict
   output reg               resp_valid,
   output reg  [1:0]        resp_verdict,
   output reg               flash_commit,
   output reg               lock_we,
   output reg  [7:0]        lock_wdata,
   output reg               dev_erase,
   output reg               flash_fault_rst,
   output reg               flash_fault_reset_flag,
   output reg  [7:0]        lock_eff
);
   reg  [7:0] lock_stored_r;   // lock byte as held in flash
   reg        lock_written_r;  // lock byte programmed since erase
   reg        fault_seen_r;    // fault occurred, flag after reset
   reg  [1:0] verdict_nxt;     // combinational verdict
   wire       any_locked;      // active lock state
   wire       tgt_locked;      // target page locked
   wire       exe_locked;      // executing page locked
   wire       tgt_lock_pg;     // target is lock page
   assign tgt_lock_pg = req_lock_byte
                      | (req_page == LOCK_PAGE[PAGE_W-1:0]);
   // two copies of the same decode: one for the page being accessed,
   // one for the page the firmware is running from; both read the lock
   // byte in force, never the stored copy, so a firmware lock write
   // stays invisible here until the next device reset
   // target page lock decode
   fls_page_lock #(.PAGE_W(PAGE_W)) u_tgt (
      .lock_val     (lock_eff),
      .page         (req_page),
      .is_lock_page (tgt_lock_pg),
      .any_locked   (any_locked),
      .page_locked  (tgt_locked)
   );
   // executing page lock decode
   fls_page_lock #(.PAGE_W(PAGE_W)) u_exe (
      .lock_val     (lock_eff),
      .page         (exec_page),
      .is_lock_page (exec_page == LOCK_PAGE[PAGE_W-1:0]),
      .any_locked   (),
      .page_locked  (exe_locked)
   );
   // verdict decision, checked in priority order:
   //  1. whole device erase: only the debug port may start it
   //  2. reserved area: debug refused, firmware faults
   //  3. erase of the lock page: debug only while nothing is locked
   //  4. lock byte already programmed: any write is frozen
   //  5. lock bit changes while locked: refused or fault
   //  6. locked target: locked-page policy by requester class
   //  7. everything else is an open page and is allowed
   // the order matters: a reserved or lock page erase request must never
   // fall through to the plain locked-page test, which would let
   // locked-page firmware erase the lock page and unlock the part
   // debug requests never produce a fault verdict, only refuse, so
   // a probe over the debug port cannot reset the device
   // the decision is purely combinational on the request fields and
   // the lock state; it is registered once below with the strobes
   always @* begin
      verdict_nxt = `FLS_V_ALLOW;
      if (req_op == `FLS_OP_DEV_ERASE) begin
         // whole erase only from the debug port
         if (req_from_debug)
            verdict_nxt = `FLS_V_ALLOW;
         else
            verdict_nxt = `FLS_V_FAULT;
      end else if (req_rsv | (req_page >= RSV_FIRST[PAGE_W-1:0]
                   && req_page != LOCK_PAGE[PAGE_W-1:0]
                   && RSV_FIRST != LOCK_PAGE)) begin
         verdict_nxt = req_from_debug ? `FLS_V_REFUSE
                                      : `FLS_V_FAULT;
      end else if (tgt_lock_pg && req_op == `FLS_OP_ERASE) begin
         // erase of lock page
         if (req_from_debug && !any_locked)
            verdict_nxt = `FLS_V_ALLOW;
         else if (req_from_debug)
            verdict_nxt = `FLS_V_REFUSE;
         else
            verdict_nxt = `FLS_V_FAULT;
      end else if (req_lock_byte && req_op == `FLS_OP_WRITE &&
                   lock_written_r) begin
         // lock byte already written: frozen
         verdict_nxt = req_from_debug ? `FLS_V_REFUSE
                                      : `FLS_V_FAULT;
      end else if (req_lock_byte && req_op == `FLS_OP_WRITE &&
                   any_locked && req_wdata != lock_eff) begin
         // changing lock bits either way
         verdict_nxt = req_from_debug ? `FLS_V_REFUSE
                                      : `FLS_V_FAULT;
      end else if (tgt_locked) begin
         // locked page policy, lock page and lock byte alike
         if (req_from_debug)
            verdict_nxt = `FLS_V_REFUSE;
         else if (!exe_locked)
            verdict_nxt = `FLS_V_FAULT;
         else
            verdict_nxt = `FLS_V_ALLOW;
      end else begin
         verdict_nxt = `FLS_V_ALLOW;
      end
   end
   // state and outputs
   // every output is a flop: the verdict and effect strobes stand for
   // exactly one cycle after the request is taken
   // reset is the device reset; it loads the reset cause flag from the
   // fault memory and the lock byte in force from the stored copy,
   // which is how firmware lock writes come to take effect
   // while the clock enable is low nothing but reset moves, strobes included
   // a fault pulse asks the system for a device reset; the host side
   // is expected to pull reset low on the following edge
   always @(posedge ref_clk) begin
      if (!rstn) begin
         resp_valid      <= 1'b0;
         resp_verdict    <= 2'h0;
         flash_commit    <= 1'b0;
         lock_we         <= 1'b0;
         lock_wdata      <= 8'h00;
         dev_erase       <= 1'b0;
         flash_fault_rst <= 1'b0;
         // flag shows a fault caught before reset
         flash_fault_reset_flag <= fault_seen_r;
         fault_seen_r    <= 1'b0;
         // stored lock byte takes effect at reset
         lock_eff        <= lock_stored_r;
      end else if (clk_en) begin
         resp_valid      <= req_valid;
         resp_verdict    <= verdict_nxt;
         flash_commit    <= req_valid && verdict_nxt == `FLS_V_ALLOW;
         lock_we         <= 1'b0;
         dev_erase       <= 1'b0;
         flash_fault_rst <= 1'b0;
         if (req_valid) begin
            if (verdict_nxt == `FLS_V_FAULT) begin
               flash_fault_rst <= 1'b1;
               fault_seen_r    <= 1'b1;
            end else if (verdict_nxt == `FLS_V_ALLOW) begin
               if (req_op == `FLS_OP_DEV_ERASE) begin
                  // device erase unlocks every page at once
                  dev_erase      <= 1'b1;
                  lock_eff       <= `FLS_LOCK_ERASED;
               end else if (req_op == `FLS_OP_ERASE && tgt_lock_pg)
                  lock_eff       <= `FLS_LOCK_ERASED;
               else if (req_op == `FLS_OP_WRITE && req_lock_byte) begin
                  lock_we    <= 1'b1;
                  lock_wdata <= req_wdata;
                  // debug writes apply now, firmware after reset
                  if (req_from_debug)
                     lock_eff <= req_wdata;
               end
            end
            // refused requests leave every effect low
         end
      end
   end
   // lock byte storage: survives device reset, cleared by erase
   // this stands for the flash cell itself, so it has no reset branch;
   // device reset must not lose a programmed lock byte
   // the written marker keeps the byte frozen once programmed, until
   // a whole device erase or an allowed erase of the lock page
   always @(posedge ref_clk) begin
      if (clk_en && req_valid && verdict_nxt == `FLS_V_ALLOW) begin
         if (req_op == `FLS_OP_DEV_ERASE ||
             (req_op == `FLS_OP_ERASE && tgt_lock_pg)) begin
            lock_stored_r  <= `FLS_LOCK_ERASED;
            lock_written_r <= 1'b0;
         end else if (req_op == `FLS_OP_WRITE && req_lock_byte) begin
            lock_stored_r  <= req_wdata;
            lock_written_r <= 1'b1;
         end
      end
   end
   // power-up content of the flash copy: erased, nothing locked,
   // nothing written; only meaningful for a fresh part
   // a real part keeps this across power cycles in the flash array
   initial begin
      lock_stored_r  = `FLS_LOCK_ERASED;
      lock_written_r = 1'b0;
   end
endmodule

/* File: bench/fls_checker_monitor.sv */
// port assertions for the flash lock security checker
`timescale 1ns/1ps
`include "fls_defines.vh"
module fls_checker_mon #(parameter PAGE_W = 6, parameter LOCK_PAGE = 63) (
   // clock, reset and request
   input logic              ref_clk, rstn, clk_en, req_valid,
   input logic              req_from_debug, req_rsv,
   input logic [1:0]        req_op,
   input logic [PAGE_W-1:0] req_page,
   // verdict side
   input logic              resp_valid, flash_commit, lock_we, dev_erase,
   input logic              flash_fault_rst, flash_fault_reset_flag,
   input logic [1:0]        resp_verdict,
   input logic [7:0]        lock_eff
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // a taken request is answered on the next edge
   property p_answer; req_valid && clk_en |=> resp_valid; endproperty
   a_answer: assert property (p_answer) else $error("request not answered");
   // debug requests never reset the device
   property p_dbg_quiet; req_valid && clk_en && req_from_debug
      |=> !flash_fault_rst; endproperty
   a_dbg_quiet: assert property (p_dbg_quiet) else $error("debug reset");
   // refused requests have no side effect
   property p_refuse; resp_valid && resp_verdict == `FLS_V_REFUSE
      |-> !(flash_commit || lock_we || dev_erase); endproperty
   a_refuse: assert property (p_refuse) else $error("refused op acted");
   // a reset request comes only with a fault verdict
   property p_fault; flash_fault_rst
      |-> resp_valid && resp_verdict == `FLS_V_FAULT; endproperty
   a_fault: assert property (p_fault) else $error("fault pulse alone");
   // reserved area: debug refused
   property p_rsv_dbg; req_valid && clk_en && req_rsv && req_from_debug &&
      req_op != `FLS_OP_DEV_ERASE |=> resp_verdict == `FLS_V_REFUSE;
   endproperty
   a_rsv_dbg: assert property (p_rsv_dbg) else $error("rsv not refused");
   // reserved area: firmware faults
   property p_rsv_fw; req_valid && clk_en && req_rsv && !req_from_debug
      |=> flash_fault_rst; endproperty
   a_rsv_fw: assert property (p_rsv_fw) else $error("rsv no fault");
   // firmware erase of the lock page always faults
   property p_fw_lkerase; req_valid && clk_en && !req_from_debug &&
      req_op == `FLS_OP_ERASE && req_page == LOCK_PAGE |=> flash_fault_rst;
   endproperty
   a_fw_lkerase: assert property (p_fw_lkerase) else $error("lk erase");
   // the reset cause flag only changes through reset
   property p_flag; $past(rstn) |-> $stable(flash_fault_reset_flag);
   endproperty
   a_flag: assert property (p_flag) else $error("flag moved");
   // whole device erase leaves nothing locked
   property p_erase; dev_erase |-> ##[0:1] lock_eff == `FLS_LOCK_ERASED;
   endproperty
   a_erase: assert property (p_erase) else $error("erase kept lock");
   c_fault: cover property (flash_fault_rst);
   c_erase: cover property (dev_erase);
   c_refuse: cover property (resp_valid && resp_verdict == `FLS_V_REFUSE);
endmodule
bind fls_checker fls_checker_mon #(.PAGE_W(PAGE_W), .LOCK_PAGE(LOCK_PAGE))
   u_mon (.ref_clk, .rstn, .clk_en, .req_valid, .req_from_debug, .req_rsv,
   .req_op, .req_page, .resp_valid, .flash_commit, .lock_we, .dev_erase,
   .flash_fault_rst, .flash_fault_reset_flag, .resp_verdict, .lock_eff);

/* File: bench/fls_fw_host.sv */
// firmware host model: turns a fault pulse into a device reset
`timescale 1ns/1ps
module fls_fw_host (
   input  logic ref_clk,
   input  logic flash_fault_rst,
   output logic host_rstn
);
   initial host_rstn = 1'b1;
   // one reset cycle follows each fault request
   always @(posedge ref_clk) host_rstn <= !flash_fault_rst;
endmodule

/* File: bench/tb_fls_checker.sv */
// self-checking bench for the flash lock security checker
`timescale 1ns/1ps
`include "fls_defines.vh"
module tb_fls_checker;
   localparam [1:0] A = `FLS_V_ALLOW, R = `FLS_V_REFUSE, F = `FLS_V_FAULT;
   logic ref_clk = 0, rstn_b = 0, req_valid = 0, d = 0, lb = 0, rs = 0;
   logic ce = 1;
   logic [1:0] op = 0, resp_verdict;
   logic [5:0] pg = 0, ex = 0;
   logic [7:0] wd = 0, lock_eff;
   logic resp_valid, ffr, flag, host_rstn;
   logic [1:0] exp_q[$];
   int n_errors = 0, n_compared = 0, cyc = 0;
   logic [31:0] s = 32'hda50;
   wire rstn = rstn_b & host_rstn;
   fls_checker dut (.ref_clk, .rstn, .clk_en(ce), .req_valid,
      .req_from_debug(d), .req_op(op), .req_page(pg), .req_lock_byte(lb),
      .req_rsv(rs), .req_wdata(wd), .exec_page(ex), .resp_valid,
      .resp_verdict, .flash_commit(), .lock_we(), .lock_wdata(),
      .dev_erase(), .flash_fault_rst(ffr), .flash_fault_reset_flag(flag),
      .lock_eff);
   fls_fw_host host (.ref_clk, .flash_fault_rst(ffr), .host_rstn);
   initial forever #25 ref_clk = ~ref_clk;
   task chk(input logic [7:0] v, e);
      n_compared++;
      if (v !== e) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, v, e);
      end
   endtask
   task end_of_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one request, expected verdict noted, then room for a fault reset
   task rq(input logic [27:0] f);
      @(posedge ref_clk);
      {d, op, pg, lb, rs, wd, ex} <= f[27:2];
      req_valid <= 1'b1;
      exp_q.push_back(f[1:0]);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   // compare each answer with the oldest note
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 5000) begin
         n_errors++;
         end_of_test();
      end
      if (resp_valid === 1'b1)
         chk(resp_verdict, exp_q.size() ? exp_q.pop_front() : 2'h3);
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rstn_b <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         s ^= s << 13; s ^= s >> 17; s ^= s << 5;
         rq({s[0], s[2:1] == 3 ? 2'h2 : s[2:1], 6'(s[8:3] % 63),
            10'h0, s[14:9], A});
      end
      rq({1'b1, 2'h0, 6'd5, 2'b01, 8'h0, 6'd0, R});
      rq({1'b0, 2'h1, 6'd5, 2'b01, 8'h0, 6'd0, F});
      chk(flag, 1);
      rq({1'b0, 2'h2, 6'd63, 2'b00, 8'h0, 6'd0, F});
      rq({1'b1, 2'h2, 6'd63, 2'b00, 8'h0, 6'd0, A});
      rq({1'b0, 2'h0, 6'd63, 2'b10, 8'h0, 6'd0, A});
      rq({1'b0, 2'h1, 6'd63, 2'b10, 8'hF0, 6'd0, A});
      chk(lock_eff, 8'hFF);
      rstn_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn_b <= 1'b1;
      @(posedge ref_clk);
      chk(lock_eff, 8'hF0);
      chk(flag, 8'h0);
      rq({1'b1, 2'h0, 6'd3, 2'b00, 8'h0, 6'd0, R});
      rq({1'b0, 2'h0, 6'd3, 2'b00, 8'h0, 6'd20, F});
      rq({1'b0, 2'h1, 6'd3, 2'b00, 8'h0, 6'd3, A});
      rq({1'b1, 2'h1, 6'd63, 2'b00, 8'h0, 6'd0, R});
      rq({1'b0, 2'h0, 6'd63, 2'b00, 8'h0, 6'd3, A});
      rq({1'b0, 2'h0, 6'd63, 2'b10, 8'h0, 6'd20, F});
      rq({1'b1, 2'h0, 6'd63, 2'b10, 8'h0, 6'd0, R});
      rq({1'b1, 2'h2, 6'd63, 2'b00, 8'h0, 6'd0, R});
      rq({1'b0, 2'h2, 6'd63, 2'b00, 8'h0, 6'd3, F});
      rq({1'b1, 2'h1, 6'd63, 2'b10, 8'h00, 6'd0, R});
      rq({1'b0, 2'h1, 6'd63, 2'b10, 8'hF8, 6'd3, F});
      rq({1'b1, 2'h0, 6'd20, 2'b00, 8'h0, 6'd0, A});
      // a device erase offered while the clock enable is low is lost
      @(posedge ref_clk);
      ce <= 1'b0;
      {d, op, pg, lb, rs, wd, ex} <= {1'b1, 2'h3, 6'd0, 10'h0, 6'd0};
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      @(posedge ref_clk);
      ce <= 1'b1;
      chk(lock_eff, 8'hF0);
      rq({1'b1, 2'h3, 6'd0, 2'b00, 8'h0, 6'd0, A});
      chk(lock_eff, 8'hFF);
      end_of_test();
   end
endmodule
